// ### bench/ipc_irq_model.sv
/*
 * Behavioural interrupt side: idle wake request and the two external interrupt pins.
 * Assumes the bench pulses fire for one cycle and sets hold_cyc in the same cycle.
 */
module ipc_irq_model (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [2:0] fire,
	input  wire logic [7:0] hold_cyc,
	output      logic       irq_wake_req,
	output      logic       ext_irq0_n,
	output      logic       ext_irq1_n,
	output      logic       ext_irq0_en,
	output      logic       ext_irq1_en
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] cnt;
	logic [2:0] act;

	// Source stays asserted for hold_cyc + 1 cycles, long enough for the oscillator
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt <= 8'h00;
			act <= 3'h0;
		end else if (fire != 3'h0) begin
			act <= fire;
			cnt <= hold_cyc;
		end else if (cnt != 8'h00) begin
			cnt <= cnt - 8'h01;
		end else begin
			act <= 3'h0;
		end
	end

	// Pins are level sensitive, active low, and always enabled
	assign irq_wake_req = act[0];
	assign ext_irq0_n   = !act[1];
	assign ext_irq1_n   = !act[2];
	assign ext_irq0_en  = 1'b1;
	assign ext_irq1_en  = 1'b1;
endmodule : ipc_irq_model

// ### bench/ipc_top_tb.sv
/*
 * Self-checking bench of the idle / power-down controller over APB.
 * Assumes the register map and timing given in ipc_defines.svh.
 */
`include "ipc_defines.svh"

module ipc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ipc_pkg::*;

	localparam logic [11:0] POWER_CONTROL_REG_A = 12'(`IPC_POWER_CONTROL_REG_IDX * 4);
	localparam logic [11:0] BAD_A  = 12'h100;
	localparam logic [11:0] STAT_A = 12'(`IPC_STAT_IDX * 4);

	logic         clk;
	logic         rst_b;
	ipc_apb_req_t req;
	ipc_apb_rsp_t rsp;
	logic         reset_pin;
	logic         adc_idle_conv;
	logic         adc_conv_done;
	logic [2:0]   fire;
	logic [7:0]   hold_cyc;
	logic         wake, irq0_n, irq1_n, en0, en1;
	ipc_pwr_t     pwr;
	ipc_mode_t    mode;
	int           miscompares, checks, pcz_cnt, p;
	logic [31:0]  rd;
	logic         err;
	logic [7:0]   v;

	ipc_top ipc_top_i (.clk(clk), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp),
		.reset_pin(reset_pin), .ext_irq0_n(irq0_n), .ext_irq1_n(irq1_n),
		.ext_irq0_en(en0), .ext_irq1_en(en1), .irq_wake_req(wake),
		.adc_idle_conv(adc_idle_conv), .adc_conv_done(adc_conv_done),
		.pwr(pwr), .mode(mode));

	ipc_irq_model ipc_irq_model_i (.clk(clk), .rst_b(rst_b), .fire(fire),
		.hold_cyc(hold_cyc), .irq_wake_req(wake), .ext_irq0_n(irq0_n),
		.ext_irq1_n(irq1_n), .ext_irq0_en(en0), .ext_irq1_en(en1));

	// Clock and fetch-restart pulse counter
	always #2.5 clk = ~clk;
	always @(posedge clk) if (pwr.pc_load_zero === 1'b1) pcz_cnt <= pcz_cnt + 1;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic chk_pwr(input logic [6:0] exp, input logic [6:0] m);
		chk({25'h0, pwr & m}, {25'h0, exp}, "controls");
	endtask : chk_pwr

	// Setup, then access held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		req.psel    <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite  <= wr;
		req.paddr   <= a;
		req.pwdata  <= d;
		@(posedge clk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		rd  = rsp.prdata;
		err = rsp.pslverr;
		chk(32'(n < 20), 32'h1, "pready");
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic wait_mode(input ipc_mode_t m, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (mode !== m && n < lim);
		chk(32'(mode), 32'(m), "mode");
	endtask : wait_mode

	task automatic fire_irq(input logic [2:0] f, input logic [7:0] h);
		fire     <= f;
		hold_cyc <= h;
		@(posedge clk);
		fire <= 3'h0;
	endtask : fire_irq

	task automatic end_of_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	// Watchdog
	initial begin
		#50000;
		miscompares++;
		end_of_test();
	end

	initial begin
		{clk, rst_b, reset_pin, adc_idle_conv, adc_conv_done, fire, hold_cyc} = '0;
		{miscompares, checks, pcz_cnt} = '0;
		req = '0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		wait_mode(IPC_RUN, 8);
		apb(1'b0, POWER_CONTROL_REG_A, 32'h0);
		chk(rd, 32'h10, "power_control_reg reset");
		apb(1'b0, BAD_A, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped");
		// Idle, interrupt wake
		apb(1'b1, POWER_CONTROL_REG_A, 32'h01);
		wait_mode(IPC_IDLE, 3);
		chk_pwr(7'h38, 7'h7E);
		apb(1'b0, STAT_A, 32'h0);
		chk(rd, 32'h1, "status idle");
		fire_irq(3'h1, 8'h04);
		wait_mode(IPC_RUN, 6);
		chk_pwr(7'h78, 7'h7E);
		apb(1'b0, POWER_CONTROL_REG_A, 32'h0);
		chk(rd, 32'h00, "idle bit");
		// Idle in converter mode, conversion done wake
		apb(1'b1, POWER_CONTROL_REG_A, 32'h01);
		wait_mode(IPC_IDLE, 3);
		adc_idle_conv <= 1'b1;
		adc_conv_done <= 1'b1;
		@(posedge clk);
		adc_conv_done <= 1'b0;
		wait_mode(IPC_RUN, 4);
		adc_idle_conv <= 1'b0;
		// Both bits, external interrupt wake held until release
		apb(1'b1, POWER_CONTROL_REG_A, 32'h1F);
		wait_mode(IPC_PDOWN, 3);
		chk_pwr(7'h00, 7'h76);
		fire_irq(3'h4, 8'h14);
		wait_mode(IPC_PD_WAIT, 8);
		chk_pwr(7'h30, 7'h70);
		repeat (6) @(posedge clk);
		chk(32'(mode), 32'(IPC_PD_WAIT), "held");
		wait_mode(IPC_RUN, 40);
		apb(1'b0, POWER_CONTROL_REG_A, 32'h0);
		chk(rd, 32'h1C, "pd exit");
		// Reset pin wake from idle and from power-down
		for (int i = 0; i < 2; i++) begin
			v = (i == 0) ? 8'h0D : 8'h0E;
			apb(1'b1, POWER_CONTROL_REG_A, {24'h0, v});
			wait_mode((i == 0) ? IPC_IDLE : IPC_PDOWN, 3);
			reset_pin <= 1'b1;
			wait_mode(IPC_RST_WIN, 8);
			chk_pwr(7'h50, 7'h58);
			wait_mode(IPC_CORE_RST, 12);
			chk_pwr(7'h06, 7'h06);
			p = pcz_cnt;
			reset_pin <= 1'b0;
			wait_mode(IPC_RUN, 10);
			repeat (2) @(posedge clk);
			chk(32'(pcz_cnt - p), 32'h1, "fetch zero");
			apb(1'b0, POWER_CONTROL_REG_A, 32'h0);
			chk(rd & 32'h0F, 32'h0, "power_control_reg cleared");
		end
		end_of_test();
	end
endmodule : ipc_top_tb

// ### hdl/ipc_sync.sv
/*
 * Three-flop synchroniser for pins; a change is taken once the second and third
 * flops agree.
 * Assumes the inputs are asynchronous to clk and held for several clock periods.
 */
`include "ipc_defines.svh"

module ipc_sync #(
	parameter int             W         = 3,
	parameter logic [W-1:0]   RESET_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] din,
	output      logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] stable;
	} ipc_sync_st_t;

	ipc_sync_st_t q;
	ipc_sync_st_t next_q;

	// Shift chain; the first stage feeds only the second
	always_comb begin
		next_q    = q;
		next_q.s1 = din;
		next_q.s2 = q.s1;
		next_q.s3 = q.s2;
		for (int i = 0; i < W; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				next_q.stable[i] = q.s3[i];
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
		end else begin
			q <= next_q;
		end
	end

	assign dout = q.stable;

endmodule : ipc_sync

// ### hdl/ipc_top.sv
/*
 * Idle / power-down controller: power control register on APB, mode sequencer and
 * the clock, oscillator, RAM-access and port controls for the core.
 * Assumes the interrupt controller supplies enable levels on clk, the CPU gates
 * its clock with cpu_clk_en, and the reset pin and external interrupts are pins.
 */
`include "ipc_defines.svh"

module ipc_top (
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire ipc_pkg::ipc_apb_req_t apb_req,
	output      ipc_pkg::ipc_apb_rsp_t apb_rsp,
	input  wire logic                  reset_pin,
	input  wire logic                  ext_irq0_n,
	input  wire logic                  ext_irq1_n,
	input  wire logic                  ext_irq0_en,
	input  wire logic                  ext_irq1_en,
	input  wire logic                  irq_wake_req,
	input  wire logic                  adc_idle_conv,
	input  wire logic                  adc_conv_done,
	output      ipc_pkg::ipc_pwr_t     pwr,
	output      ipc_pkg::ipc_mode_t    mode
);
	import ipc_pkg::*;

	localparam int WIN_CYC = `IPC_RST_WIN_CYC;
	localparam logic [3:0] WIN_LAST = 4'(WIN_CYC - 1);

	typedef struct packed {
		ipc_mode_t    state;
		ipc_power_control_reg_t    power_control_reg;
		logic [3:0]   win_cnt;
		ipc_apb_rsp_t rsp;
		ipc_pwr_t     pwr;
	} ipc_state_t;

	ipc_state_t q;
	ipc_state_t next_q;

	logic [2:0] pins_sync;
	logic       rstpin;
	logic       irq0_low;
	logic       irq1_low;
	logic       pd_wake;
	logic       pd_released;
	logic       acc_ok;
	logic       wr_power_control_reg;
	logic [7:0] power_control_reg_byte;

	// Byte address of a register index
	function automatic logic [`IPC_ADDR_W-1:0] ipc_addr(input logic [7:0] idx);
		ipc_addr = `IPC_ADDR_W'({idx, 2'b00});
	endfunction : ipc_addr

	// Reset pin and both external interrupts pass the pin synchroniser
	ipc_sync #(
		.W         (3),
		.RESET_VAL (`IPC_SYNC_RST)
	) u_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.din   ({ext_irq1_n, ext_irq0_n, reset_pin}),
		.dout  (pins_sync)
	);

	assign rstpin      = pins_sync[0];
	assign irq0_low    = !pins_sync[1];
	assign irq1_low    = !pins_sync[2];
	assign pd_wake     = (irq0_low && ext_irq0_en) || (irq1_low && ext_irq1_en);
	assign pd_released = !(irq0_low && ext_irq0_en) && !(irq1_low && ext_irq1_en);
	assign acc_ok      = apb_req.psel && apb_req.penable && q.rsp.pready && !q.rsp.pslverr;
	assign wr_power_control_reg     = acc_ok && apb_req.pwrite
		&& (apb_req.paddr == ipc_addr(`IPC_POWER_CONTROL_REG_IDX));

	// Readback image of the power control register, idle in bit 0 and power-down in bit 1
	always_comb begin
		power_control_reg_byte                 = 8'h00;
		power_control_reg_byte[`IPC_IDL_BIT]   = q.power_control_reg.idle_request_bit;
		power_control_reg_byte[`IPC_PD_BIT]    = q.power_control_reg.powerdown_request_bit;
		power_control_reg_byte[`IPC_UF0_BIT]   = q.power_control_reg.user_flag_0;
		power_control_reg_byte[`IPC_UF1_BIT]   = q.power_control_reg.user_flag_1;
		power_control_reg_byte[`IPC_POF_BIT]   = q.power_control_reg.power_off_flag;
	end

	// Bus answer, mode sequencer and the derived controls
	always_comb begin
		next_q                  = q;
		next_q.rsp.pready       = 1'b0;
		next_q.rsp.pslverr      = 1'b0;
		// Setup phase prepares the answer for the first access edge
		if (apb_req.psel && !apb_req.penable && !q.rsp.pready) begin
			next_q.rsp.pready = 1'b1;
			next_q.rsp.prdata = 32'h0000_0000;
			if (apb_req.paddr == ipc_addr(`IPC_POWER_CONTROL_REG_IDX)) begin
				next_q.rsp.prdata[7:0] = power_control_reg_byte;
			end else if (apb_req.paddr == ipc_addr(`IPC_STAT_IDX)) begin
				next_q.rsp.prdata[`IPC_STAT_MODE_LSB +: 3] = q.state;
				next_q.rsp.prdata[`IPC_STAT_RAMBLK_BIT]    = !q.pwr.ram_access_en;
				next_q.rsp.prdata[`IPC_STAT_RSTPIN_BIT]    = rstpin;
			end else begin
				next_q.rsp.pslverr = 1'b1;
			end
		end
		// Flag bits with no mode effect follow the write
		if (wr_power_control_reg) begin
			next_q.power_control_reg.user_flag_0    = apb_req.pwdata[`IPC_UF0_BIT];
			next_q.power_control_reg.user_flag_1    = apb_req.pwdata[`IPC_UF1_BIT];
			next_q.power_control_reg.power_off_flag = apb_req.pwdata[`IPC_POF_BIT];
		end
		next_q.win_cnt = 4'h0;
		unique case (q.state)
			IPC_RUN: begin
				if (rstpin) begin
					next_q.state = IPC_CORE_RST;
				end else if (wr_power_control_reg && apb_req.pwdata[`IPC_PD_BIT]) begin
					// Power-down wins and idle is dropped so its exit lands in run
					next_q.power_control_reg.powerdown_request_bit = 1'b1;
					next_q.power_control_reg.idle_request_bit      = 1'b0;
					next_q.state                      = IPC_PDOWN;
				end else if (wr_power_control_reg && apb_req.pwdata[`IPC_IDL_BIT]) begin
					next_q.power_control_reg.idle_request_bit = 1'b1;
					next_q.state                 = IPC_IDLE;
				end
			end
			IPC_IDLE: begin
				if (rstpin) begin
					next_q.power_control_reg.idle_request_bit = 1'b0;
					next_q.state                 = IPC_RST_WIN;
				end else if (irq_wake_req || (adc_idle_conv && adc_conv_done)) begin
					next_q.power_control_reg.idle_request_bit = 1'b0;
					next_q.state                 = IPC_RUN;
				end
			end
			IPC_PDOWN: begin
				if (rstpin) begin
					next_q.power_control_reg.powerdown_request_bit = 1'b0;
					next_q.state                      = IPC_RST_WIN;
				end else if (pd_wake) begin
					next_q.power_control_reg.powerdown_request_bit = 1'b0;
					next_q.state                      = IPC_PD_WAIT;
				end
			end
			IPC_PD_WAIT: begin
				if (rstpin) begin
					next_q.state = IPC_RST_WIN;
				end else if (pd_released) begin
					next_q.state = IPC_RUN;
				end
			end
			IPC_RST_WIN: begin
				// Core runs briefly with RAM blocked before the internal reset
				next_q.win_cnt = q.win_cnt + 4'h1;
				if (q.win_cnt == WIN_LAST) begin
					next_q.state   = IPC_CORE_RST;
					next_q.win_cnt = 4'h0;
				end
			end
			IPC_CORE_RST: begin
				// Core SFRs except power_off_flag return to reset values; RAM is never touched
				next_q.power_control_reg.powerdown_request_bit = 1'b0;
				next_q.power_control_reg.idle_request_bit      = 1'b0;
				next_q.power_control_reg.user_flag_0           = 1'b0;
				next_q.power_control_reg.user_flag_1           = 1'b0;
				if (!rstpin) begin
					next_q.state = IPC_RUN;
				end
			end
		endcase
		// Controls follow the next mode so every one leaves a flop
		next_q.pwr.cpu_clk_en = (next_q.state == IPC_RUN) || (next_q.state == IPC_RST_WIN)
			|| (next_q.state == IPC_CORE_RST);
		next_q.pwr.periph_clk_en    = (next_q.state != IPC_PDOWN);
		next_q.pwr.osc_run          = (next_q.state != IPC_PDOWN);
		next_q.pwr.ram_access_en    = (next_q.state != IPC_RST_WIN);
		next_q.pwr.ports_force_high = (next_q.state == IPC_CORE_RST);
		next_q.pwr.core_rst         = (next_q.state == IPC_CORE_RST);
		next_q.pwr.pc_load_zero     = (q.state == IPC_CORE_RST)
			&& (next_q.state == IPC_RUN);
	end

	// State register; reset holds the core in its internal reset
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q                        <= '0;
			q.state                  <= IPC_CORE_RST;
			q.power_control_reg                   <= 5'(`IPC_POWER_CONTROL_REG_RST >> `IPC_IDL_BIT);
			q.pwr.cpu_clk_en         <= 1'b1;
			q.pwr.periph_clk_en      <= 1'b1;
			q.pwr.osc_run            <= 1'b1;
			q.pwr.ram_access_en      <= 1'b1;
			q.pwr.ports_force_high   <= 1'b1;
			q.pwr.core_rst           <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	assign apb_rsp = q.rsp;
	assign pwr     = q.pwr;
	assign mode    = q.state;

	default clocking ck @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_idle_rst_enter;
		q.state == IPC_IDLE && rstpin;
	endsequence

	sequence s_run_window;
		(q.state == IPC_RST_WIN && q.pwr.cpu_clk_en && !q.pwr.ram_access_en) [*8];
	endsequence

	sequence s_core_reset;
		q.state == IPC_CORE_RST && q.pwr.core_rst && q.pwr.ports_force_high;
	endsequence

	chk_idle_clock_gate: assert property (
		q.state == IPC_IDLE |-> !q.pwr.cpu_clk_en && q.pwr.periph_clk_en)
		else $error("idle mode left cpu clock running or stopped peripherals");

	chk_idle_entry_now: assert property (
		q.state == IPC_RUN && !rstpin && wr_power_control_reg && apb_req.pwdata[1:0] == 2'b01
		|=> q.state == IPC_IDLE && !q.pwr.cpu_clk_en && q.power_control_reg.idle_request_bit)
		else $error("idle write did not stop the cpu at once");

	chk_both_bits_pd: assert property (
		q.state == IPC_RUN && !rstpin && wr_power_control_reg && apb_req.pwdata[1:0] == 2'b11
		|=> q.state == IPC_PDOWN && !q.power_control_reg.idle_request_bit)
		else $error("both request bits did not give power-down alone");

	chk_idle_irq_exit: assert property (
		q.state == IPC_IDLE && !rstpin && irq_wake_req
		|=> q.state == IPC_RUN && q.pwr.cpu_clk_en && !q.power_control_reg.idle_request_bit)
		else $error("interrupt did not end idle");

	chk_reset_window: assert property (
		s_idle_rst_enter |=> s_run_window ##1 s_core_reset)
		else $error("reset wake window not eight cycles before internal reset");

	chk_vector_zero: assert property (
		q.state == IPC_CORE_RST && !rstpin |=> q.pwr.pc_load_zero ##1 !q.pwr.pc_load_zero)
		else $error("fetch from zero not pulsed after internal reset");

	chk_adc_idle_exit: assert property (
		q.state == IPC_IDLE && !rstpin && adc_idle_conv && adc_conv_done
		|=> q.state == IPC_RUN)
		else $error("conversion completion did not end idle");

	chk_pdown_freeze: assert property (
		q.state == IPC_PDOWN |-> !q.pwr.osc_run && !q.pwr.periph_clk_en && !q.pwr.cpu_clk_en)
		else $error("a clock runs in power-down");

	chk_pd_wake_hold: assert property (
		q.state == IPC_PDOWN && !rstpin && pd_wake
		|=> (q.pwr.osc_run && !q.pwr.cpu_clk_en) until (q.state != IPC_PD_WAIT))
		else $error("cpu restarted before wake interrupt release");

	chk_pd_bit_reset: assert property (
		q.pwr.core_rst |=> !q.power_control_reg.powerdown_request_bit)
		else $error("power-down bit survived reset");

endmodule : ipc_top

// ### include/ipc_defines.svh
/*
 * Constants of the idle / power-down controller: register indexes, field positions,
 * reset values and timing counts.
 * Assumes a 200 MHz system clock and a word-per-register APB map.
 */
`ifndef IPC_DEFINES_SVH
`define IPC_DEFINES_SVH

// Bus geometry
`define IPC_ADDR_W          12
`define IPC_DATA_W          32

// Register indexes; byte address is four times the index
`define IPC_POWER_CONTROL_REG_IDX        8'h87
`define IPC_STAT_IDX        8'h90

// Power control register field positions
`define IPC_IDL_BIT         0
`define IPC_PD_BIT          1
`define IPC_UF0_BIT         2
`define IPC_UF1_BIT         3
`define IPC_POF_BIT         4

// Reset values
`define IPC_POWER_CONTROL_REG_RST        8'h10
`define IPC_SYNC_RST        3'h6

// Status register field positions
`define IPC_STAT_MODE_LSB   0
`define IPC_STAT_RAMBLK_BIT 8
`define IPC_STAT_RSTPIN_BIT 9

// Timing
`define IPC_CLK_PERIOD_PS   5000
`define IPC_RST_WIN_NS      40
`define IPC_RST_WIN_CYC     ((`IPC_RST_WIN_NS * 1000) / `IPC_CLK_PERIOD_PS)

`endif

// ### include/ipc_pkg.sv
/*
 * Types of the idle / power-down controller: modes, bus carriers and the clock,
 * reset and access controls handed to the CPU core and peripherals.
 * Assumes ipc_defines.svh is on the include path.
 */
`include "ipc_defines.svh"

package ipc_pkg;

	typedef enum logic [2:0] {
		IPC_RUN,
		IPC_IDLE,
		IPC_PDOWN,
		IPC_PD_WAIT,
		IPC_RST_WIN,
		IPC_CORE_RST
	} ipc_mode_t;

	typedef struct packed {
		logic                     psel;
		logic                     penable;
		logic                     pwrite;
		logic [`IPC_ADDR_W-1:0]   paddr;
		logic [`IPC_DATA_W-1:0]   pwdata;
	} ipc_apb_req_t;

	typedef struct packed {
		logic                     pready;
		logic [`IPC_DATA_W-1:0]   prdata;
		logic                     pslverr;
	} ipc_apb_rsp_t;

	typedef struct packed {
		logic cpu_clk_en;
		logic periph_clk_en;
		logic osc_run;
		logic ram_access_en;
		logic ports_force_high;
		logic core_rst;
		logic pc_load_zero;
	} ipc_pwr_t;

	typedef struct packed {
		logic power_off_flag;
		logic user_flag_1;
		logic user_flag_0;
		logic powerdown_request_bit;
		logic idle_request_bit;
	} ipc_power_control_reg_t;

endpackage : ipc_pkg
